// [dv/irq_summary_ctrl_test.sv]
// self-checking bench for the interrupt request, summary and clear block
// assumes the zero-wait AHB-Lite slave and register map of the design
`timescale 1ns/100ps
`default_nettype none
module irq_summary_ctrl_test;
  ////////////////////////////////////////////////////////////////////////
  // clock, reset and bus stimulus
  logic i_clk = 1'b0; // 10 MHz core clock
  logic i_rst = 1'b1; // held for four edges
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  wire logic hready; // single slave: its ready is the bus ready
  logic [31:0] hrdata;
  logic [1:0] hresp;
  irq_sum_pkg::hw_src_s src = '0; // hardware sources, all low
  logic priv = 1'b1; // start inside privileged code
  logic hit = 1'b0; // cache fill hit pulse
  logic par, cpu_irq, irq;
  logic [31:0] rdv; // last read data
  int n_mismatch = 0;
  int checks = 0;
  int zeros = 0;
  localparam logic IRQ_BUS = 1'b0; // lvl looks at o_irq
  localparam logic IRQ_CPU = 1'b1; // lvl looks at o_cpu_irq

  always #50 i_clk = ~i_clk;

  irq_summary_ctrl u_irq_summary_ctrl (
    .i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .i_src(src),
    .i_privileged_code(priv), .i_bc_fill_hit(hit),
    .o_bad_fill_parity(par), .o_cpu_irq(cpu_irq), .o_irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // compare seen against expected, count both outcomes
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // bus master: waits for ready at each phase, bounded
  task automatic rdy();
    int n;
    n = 0;
    @(posedge i_clk);
    while (hready !== 1'b1 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20)
    begin
      n_mismatch++;
      $display("[ERR] %0t bus wait timed out", $time);
      summarize();
    end
  endtask

  // one single word transfer; read data lands in rdv
  task automatic bus(input logic [31:0] a, input logic wr,
    input logic [31:0] wd);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    rdv = hrdata;
    chk({30'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rc(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rdv, e);
  endtask

  // source pulse long enough for the synchroniser, then settle
  task automatic pulse(input irq_sum_pkg::hw_src_s s);
    @(posedge i_clk);
    src <= s;
    repeat (3) @(posedge i_clk);
    src <= '0;
    repeat (4) @(posedge i_clk);
  endtask

  // let a registered level output follow a register write, then
  // sample it live; a by-value copy would be stale by then
  task automatic lvl(input logic sel, input logic exp);
    repeat (2) @(posedge i_clk);
    #1 chk({31'h0, (sel == IRQ_CPU) ? cpu_irq : irq}, {31'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    logic [31:0] e;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    rc(irq_sum_pkg::A_SWREQ_LO, 32'h0);
    rc(irq_sum_pkg::A_SUM_LO, 32'h0);
    done("reset");
    // software requests: only 28:14 hold, enable gates summary
    wr(irq_sum_pkg::A_SWREQ_LO, 32'hffff_ffff);
    rc(irq_sum_pkg::A_SWREQ_LO, 32'h1fff_c000);
    rc(irq_sum_pkg::A_SWREQ_HI, 32'h0);
    rc(irq_sum_pkg::A_SUM_LO, 32'h0);
    wr(irq_sum_pkg::A_ENMODE_LO, 32'h0000_8000);
    rc(irq_sum_pkg::A_SUM_LO, 32'h0000_8000);
    rc(32'h0000_0040, 32'h0);
    rc(irq_sum_pkg::A_CLR_LO, 32'h0);
    done("software");
    // traps: global enable first off, then every mode code
    wr(irq_sum_pkg::A_TRAP, 32'h0000_00ff);
    wr(irq_sum_pkg::A_ENMODE_LO, 32'h0000_8018);
    rc(irq_sum_pkg::A_SUM_LO, 32'h0000_8000);
    for (int m = 0; m < 4; m++)
    begin
      wr(irq_sum_pkg::A_ENMODE_LO, 32'h0000_a000 | (m << 3));
      e = 32'h0000_8008 | (m >= 1 ? 32'h10 : 32'h0);
      e = e | (m >= 2 ? 32'h200 : 32'h0) | (m == 3 ? 32'h400 : 32'h0);
      rc(irq_sum_pkg::A_SUM_LO, e);
    end
    rc(irq_sum_pkg::A_TRAP, 32'h0000_00ff);
    done("traps");
    // edge sources: latch, report, survive null clears, then clear
    wr(irq_sum_pkg::A_ENMODE_LO, 32'he000_8000);
    wr(irq_sum_pkg::A_ENMODE_HI, 32'h0000_007f);
    rc(irq_sum_pkg::A_ENMODE_HI, 32'h0000_007f);
    pulse('{ext: 6'h0, sl: 1'b1, cr: 1'b1, pc: 2'h3, mchk: 1'b1});
    rc(irq_sum_pkg::A_SUM_LO, 32'he000_8000);
    rc(irq_sum_pkg::A_SUM_HI, 32'h1);
    rc(irq_sum_pkg::A_EVT_STAT, 32'h1e);
    lvl(IRQ_BUS, 1'b0);
    wr(irq_sum_pkg::A_EVT_MASK, 32'h3f);
    lvl(IRQ_BUS, 1'b1);
    wr(irq_sum_pkg::A_CLR_LO, 32'h0);
    wr(irq_sum_pkg::A_CLR_HI, 32'hffff_fffe);
    wr(irq_sum_pkg::A_CLR_LO, 32'h0bff_ffff);
    rc(irq_sum_pkg::A_SUM_LO, 32'he000_8000);
    rc(irq_sum_pkg::A_SUM_HI, 32'h1);
    rc(irq_sum_pkg::A_MISC, 32'h2);
    wr(irq_sum_pkg::A_CLR_LO, 32'hd000_0000);
    rc(irq_sum_pkg::A_SUM_LO, 32'h2000_8000);
    rc(irq_sum_pkg::A_MISC, 32'h0);
    wr(irq_sum_pkg::A_CLR_LO, 32'h2000_0000);
    wr(irq_sum_pkg::A_CLR_HI, 32'h1);
    rc(irq_sum_pkg::A_SUM_LO, 32'h0000_8000);
    rc(irq_sum_pkg::A_SUM_HI, 32'h0);
    wr(irq_sum_pkg::A_EVT_STAT, 32'h3f);
    lvl(IRQ_BUS, 1'b0);
    done("edge sources");
    // fill parity: armed once, second hit is clean
    wr(irq_sum_pkg::A_CLR_LO, 32'h0400_0000);
    rc(irq_sum_pkg::A_MISC, 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge i_clk);
      hit <= 1'b1;
      @(posedge i_clk);
      hit <= 1'b0;
      #1 chk({31'h0, par}, {31'h0, i == 0});
      @(posedge i_clk);
      #1 chk({31'h0, par}, 32'h0);
    end
    rc(irq_sum_pkg::A_MISC, 32'h0);
    done("fill parity");
    // arrival racing a summary read: swept across read timing
    chk({31'h0, cpu_irq}, 32'h1);
    for (int d = 0; d < 4; d++)
    begin
      @(posedge i_clk);
      src.ext[d] <= 1'b1;
      repeat (d) @(posedge i_clk);
      bus(irq_sum_pkg::A_SUM_LO, 1'b0, 32'h0);
      if (rdv === 32'h0)
        zeros++;
      // a second read ORed in recovers a race-zeroed first one
      e = rdv;
      bus(irq_sum_pkg::A_SUM_LO, 1'b0, 32'h0);
      chk(e | rdv, 32'h0000_8000);
    end
    chk({31'h0, zeros == 1}, 32'h1);
    rc(irq_sum_pkg::A_MISC, 32'h4);
    lvl(IRQ_CPU, 1'b0);
    priv <= 1'b0;
    repeat (2) @(posedge i_clk);
    lvl(IRQ_CPU, 1'b1);
    rc(irq_sum_pkg::A_SUM_HI, 32'h1e);
    done("race");
    summarize();
  end
endmodule
`default_nettype wire

// [inc/irq_sum_pkg.sv]
// constants, field positions and carrier types of the interrupt
// request, summary and clear block; used by irq_summary_ctrl and the bench
package irq_sum_pkg;
  // register byte addresses on the bus
  localparam logic [31:0] A_SWREQ_LO = 32'h0000_0000;
  localparam logic [31:0] A_SWREQ_HI = 32'h0000_0004;
  localparam logic [31:0] A_SUM_LO = 32'h0000_0008;
  localparam logic [31:0] A_SUM_HI = 32'h0000_000c;
  localparam logic [31:0] A_CLR_LO = 32'h0000_0010;
  localparam logic [31:0] A_CLR_HI = 32'h0000_0014;
  localparam logic [31:0] A_ENMODE_LO = 32'h0000_0018;
  localparam logic [31:0] A_ENMODE_HI = 32'h0000_001c;
  localparam logic [31:0] A_TRAP = 32'h0000_0020;
  localparam logic [31:0] A_EVT_STAT = 32'h0000_0024;
  localparam logic [31:0] A_EVT_MASK = 32'h0000_0028;
  localparam logic [31:0] A_MISC = 32'h0000_002c;
  // low-word positions (bit 0..31 of the 64-bit register)
  localparam int SW_LSB = 14;
  localparam int SW_MSB = 28;
  localparam int SW_W = 15;
  localparam int PC_LSB = 29;
  localparam int CR_BIT = 31;
  localparam int MCHK_BIT = 28;
  localparam int FORCE_BAD_FILL_PARITY_BIT = 26;
  localparam int GLOBAL_TRAP_ENABLE_BIT = 13;
  localparam int CM_LSB = 3;
  localparam int TRAP_K_BIT = 3;
  localparam int TRAP_E_BIT = 4;
  localparam int TRAP_S_BIT = 9;
  localparam int TRAP_U_BIT = 10;
  // high-word positions (bit 32 and up, minus 32)
  localparam int SL_HI_BIT = 0;
  localparam int EI_HI_LSB = 1;
  localparam int EI_W = 6;
  // trap register: enables [3:0], requests [7:4], index is mode code
  localparam int TRAP_REQ_LSB = 4;
  // event status / mask bit positions
  localparam int EV_EXT = 0;
  localparam int EV_SL = 1;
  localparam int EV_CR = 2;
  localparam int EV_PC = 3;
  localparam int EV_MCHK = 4;
  localparam int EV_LOST = 5;
  localparam int EV_W = 6;
  // misc status bit positions
  localparam int MS_ARMED = 0;
  localparam int MS_MCHK = 1;
  localparam int MS_HOLD = 2;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  // processor modes, codes as held in the mode field
  typedef enum logic [1:0]
  {
    MODE_KERNEL = 2'h0,
    MODE_EXEC = 2'h1,
    MODE_SUPER = 2'h2,
    MODE_USER = 2'h3
  } mode_e;
  // hardware interrupt sources from the core
  typedef struct packed
  {
    logic [5:0] ext;
    logic sl;
    logic cr;
    logic [1:0] pc;
    logic mchk;
  } hw_src_s;
endpackage

// [verilog/irq_sticky.sv]
// bank of sticky flags: set pulses latch, clear pulses drop
// a set in the same cycle as its clear wins, so no event is lost
`timescale 1ns/100ps
`default_nettype none
module irq_sticky #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_q
);
  ////////////////////////////////////////////////////////////////
  // flag update, set over clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_q <= '0;
    else
      o_q <= i_set | (o_q & ~i_clr);
  end
endmodule
`default_nettype wire

// [verilog/irq_summary_ctrl.sv]
// interrupt request, summary and clear registers behind AHB-Lite
// assumes one clock, synchronous reset, single word transfers;
// hardware sources are asynchronous pins and are synchronised here
//
// Behaviour
// - software irq needs request and enable set
// - fifteen request bits at 28:14, rest reserved
// - summary shows only enabled pending requests
// - summary read during new arrival returns zero
// - lost request stays pending, resignals in native
// - external, serial, read-error, software bit positions
// - counter irqs at 30:29, counter 0 low
// - per-mode trap bits at 10, 9, 4, 3
// - trap bit needs enable, request, mode >= code
// - clear register write-only, writes clear requests
// - clear bits 32, 31, 30:29 drop edge requests
// - clear bit 28 drops data machine check
// - bit 26 arms one bad fill parity
// - trap also needs global trap enable
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module irq_summary_ctrl (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic [1:0] o_hresp,
  input wire irq_sum_pkg::hw_src_s i_src,
  input wire logic i_privileged_code,
  input wire logic i_bc_fill_hit,
  output logic o_bad_fill_parity,
  output logic o_cpu_irq,
  output logic o_irq
);
  ////////////////////////////////////////////////////////////////
  // declarations
  irq_sum_pkg::hw_src_s lvl_w; // synchronised source levels
  irq_sum_pkg::hw_src_s rise_w; // synchronised rising edges
  logic [4:0] edge_req_q; // latched sl, cr, pc1, pc0, mchk
  logic [4:0] edge_clr_w; // clear pulses for the same bits
  localparam int EV_W_C = irq_sum_pkg::EV_W; // event bank width
  logic [EV_W_C-1:0] ev_set_w; // event set pulses
  logic [EV_W_C-1:0] ev_clr_w; // event write-one clears
  logic [EV_W_C-1:0] ev_stat_q; // sticky event status
  logic [14:0] swreq_r; // software request bits
  logic [31:0] en_lo_r; // enable/mode low word
  logic [6:0] en_hi_r; // enable high word, bits 38:32
  logic [7:0] trap_r; // trap requests and enables
  logic [EV_W_C-1:0] ev_mask_r; // event mask
  logic armed_r; // bad fill parity armed
  logic hold_r; // signalling held after a lost read
  logic wr_pend_r; // write data phase in progress
  logic [31:0] waddr_r; // address of that write
  logic [31:0] wdata_w; // write data, qualified
  logic addr_ok_w; // address phase taken
  logic [63:0] sum_w; // live summary value
  logic [63:0] en_mask_w; // enable bits in summary layout
  logic arrival_w; // a new ext, sl, cr or pc request this cycle
  logic sum_rd_w; // summary read taken this cycle
  logic [31:0] rdata_nxt;
  logic [1:0] cm_w; // current mode code
  ////////////////////////////////////////////////////////////////
  // functions
  // true for a write data phase at a given register
  function automatic logic wr_at(input logic pend,
    input logic [31:0] a, input logic [31:0] reg_a);
    return pend && (a == reg_a);
  endfunction

  // trap pending for one mode code
  function automatic logic trap_pend(input logic [7:0] t,
    input logic gen_en, input logic [1:0] cm, input logic [1:0] m);
    return gen_en && t[m] && t[irq_sum_pkg::TRAP_REQ_LSB + 32'(m)]
      && (cm >= m);
  endfunction
  ////////////////////////////////////////////////////////////////
  // source synchroniser, pins are outside the clock domain
  irq_sync_edge #(.W($bits(irq_sum_pkg::hw_src_s))) u_sync (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_async(i_src),
    .o_level(lvl_w),
    .o_rise(rise_w)
  );
  ////////////////////////////////////////////////////////////////
  // bus address phase and write data phase tracking
  assign addr_ok_w = i_hsel && i_htrans[1] && i_hready;
  assign wdata_w = wr_pend_r ? i_hwdata : irq_sum_pkg::RST_WORD;
  assign cm_w = en_lo_r[irq_sum_pkg::CM_LSB +: 2];
  // registered write address; the data follows a cycle later
  always_ff @(posedge i_clk)
  begin
    wr_pend_r <= !i_rst && addr_ok_w && i_hwrite;
    waddr_r <= i_haddr; // only looked at while wr_pend_r is set
  end
  // slave never stalls and never errors, in reset or out of it
  always_ff @(posedge i_clk)
  begin
    o_hreadyout <= 1'b1;
    o_hresp <= irq_sum_pkg::RESP_OKAY;
  end
  ////////////////////////////////////////////////////////////////
  // edge-sensitive request latches and their clears
  // clear register is write-only: data only drops latches
  always_comb
  begin
    edge_clr_w = '0;
    if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_CLR_HI))
      edge_clr_w[4] = wdata_w[irq_sum_pkg::SL_HI_BIT];
    if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_CLR_LO))
    begin
      // only ones clear; zeros and reserved bits are ignored
      edge_clr_w[3] = wdata_w[irq_sum_pkg::CR_BIT];
      edge_clr_w[2:1] = wdata_w[irq_sum_pkg::PC_LSB +: 2];
      edge_clr_w[0] = wdata_w[irq_sum_pkg::MCHK_BIT];
    end
  end
  // a lost summary read leaves the latch set, so it stays pending
  irq_sticky #(.W(5)) u_req (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set({rise_w.sl, rise_w.cr, rise_w.pc, rise_w.mchk}),
    .i_clr(edge_clr_w),
    .o_q(edge_req_q)
  );
  ////////////////////////////////////////////////////////////////
  // software writable registers
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      swreq_r <= '0;
      en_lo_r <= irq_sum_pkg::RST_WORD;
      en_hi_r <= '0;
      trap_r <= '0;
      ev_mask_r <= '0;
    end
    else
    begin
      // only bits 28:14 are storage, the rest stay zero
      if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_SWREQ_LO))
        swreq_r <= wdata_w[irq_sum_pkg::SW_MSB:irq_sum_pkg::SW_LSB];
      if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_ENMODE_LO))
        en_lo_r <= wdata_w;
      if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_ENMODE_HI))
        en_hi_r <= wdata_w[6:0];
      if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_TRAP))
        trap_r <= wdata_w[7:0];
      if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_EVT_MASK))
        ev_mask_r <= wdata_w[EV_W_C-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////
  // summary composition
  always_comb
  begin
    sum_w = '0;
    en_mask_w = '0;
    // external levels, serial line, read error
    sum_w[32 + irq_sum_pkg::EI_HI_LSB +: 6] =
      lvl_w.ext & en_hi_r[irq_sum_pkg::EI_HI_LSB +: 6];
    sum_w[32 + irq_sum_pkg::SL_HI_BIT] =
      edge_req_q[4] & en_hi_r[irq_sum_pkg::SL_HI_BIT];
    sum_w[irq_sum_pkg::CR_BIT] =
      edge_req_q[3] & en_lo_r[irq_sum_pkg::CR_BIT];
    // counter 0 in the lower bit, counter 1 in the upper
    sum_w[irq_sum_pkg::PC_LSB +: 2] =
      edge_req_q[2:1] & en_lo_r[irq_sum_pkg::PC_LSB +: 2];
    // software level needs request and its enable
    sum_w[irq_sum_pkg::SW_MSB:irq_sum_pkg::SW_LSB] =
      swreq_r & en_lo_r[irq_sum_pkg::SW_MSB:irq_sum_pkg::SW_LSB];
    // one trap bit per mode, gated by global enable
    sum_w[irq_sum_pkg::TRAP_K_BIT] = trap_pend(trap_r,
      en_lo_r[irq_sum_pkg::GLOBAL_TRAP_ENABLE_BIT], cm_w, irq_sum_pkg::MODE_KERNEL);
    sum_w[irq_sum_pkg::TRAP_E_BIT] = trap_pend(trap_r,
      en_lo_r[irq_sum_pkg::GLOBAL_TRAP_ENABLE_BIT], cm_w, irq_sum_pkg::MODE_EXEC);
    sum_w[irq_sum_pkg::TRAP_S_BIT] = trap_pend(trap_r,
      en_lo_r[irq_sum_pkg::GLOBAL_TRAP_ENABLE_BIT], cm_w, irq_sum_pkg::MODE_SUPER);
    sum_w[irq_sum_pkg::TRAP_U_BIT] = trap_pend(trap_r,
      en_lo_r[irq_sum_pkg::GLOBAL_TRAP_ENABLE_BIT], cm_w, irq_sum_pkg::MODE_USER);
    // enable image for checking, reserved bits stay zero
    en_mask_w[38:32] = en_hi_r;
    en_mask_w[31:14] = en_lo_r[31:14];
    en_mask_w[irq_sum_pkg::TRAP_U_BIT] = trap_r[3];
    en_mask_w[irq_sum_pkg::TRAP_S_BIT] = trap_r[2];
    en_mask_w[irq_sum_pkg::TRAP_E_BIT] = trap_r[1];
    en_mask_w[irq_sum_pkg::TRAP_K_BIT] = trap_r[0];
  end
  ////////////////////////////////////////////////////////////////
  // read-race detection and event sources
  assign arrival_w = (|rise_w.ext) | rise_w.sl | rise_w.cr
    | (|rise_w.pc);
  assign sum_rd_w = addr_ok_w && !i_hwrite &&
    ((i_haddr == irq_sum_pkg::A_SUM_LO) ||
     (i_haddr == irq_sum_pkg::A_SUM_HI));

  always_comb
  begin
    ev_set_w = '0;
    ev_set_w[irq_sum_pkg::EV_EXT] = |rise_w.ext;
    ev_set_w[irq_sum_pkg::EV_SL] = rise_w.sl;
    ev_set_w[irq_sum_pkg::EV_CR] = rise_w.cr;
    ev_set_w[irq_sum_pkg::EV_PC] = |rise_w.pc;
    ev_set_w[irq_sum_pkg::EV_MCHK] = rise_w.mchk;
    ev_set_w[irq_sum_pkg::EV_LOST] = sum_rd_w && arrival_w;
    ev_clr_w = '0;
    if (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_EVT_STAT))
      ev_clr_w = wdata_w[EV_W_C-1:0];
  end

  // event status, write one to clear, set wins
  irq_sticky #(.W(EV_W_C)) u_evt (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_set(ev_set_w),
    .i_clr(ev_clr_w),
    .o_q(ev_stat_q)
  );
  ////////////////////////////////////////////////////////////////
  // read data, captured at the address phase edge
  always_comb
  begin
    rdata_nxt = irq_sum_pkg::RST_WORD;
    unique case (i_haddr)
      irq_sum_pkg::A_SWREQ_LO:
        rdata_nxt[irq_sum_pkg::SW_MSB:irq_sum_pkg::SW_LSB] = swreq_r;
      irq_sum_pkg::A_SUM_LO: rdata_nxt = sum_w[31:0];
      irq_sum_pkg::A_SUM_HI: rdata_nxt = sum_w[63:32];
      irq_sum_pkg::A_ENMODE_LO: rdata_nxt = en_lo_r;
      irq_sum_pkg::A_ENMODE_HI: rdata_nxt[6:0] = en_hi_r;
      irq_sum_pkg::A_TRAP: rdata_nxt[7:0] = trap_r;
      irq_sum_pkg::A_EVT_STAT: rdata_nxt[EV_W_C-1:0] = ev_stat_q;
      irq_sum_pkg::A_EVT_MASK: rdata_nxt[EV_W_C-1:0] = ev_mask_r;
      irq_sum_pkg::A_MISC:
      begin
        rdata_nxt[irq_sum_pkg::MS_ARMED] = armed_r;
        rdata_nxt[irq_sum_pkg::MS_MCHK] = edge_req_q[0];
        rdata_nxt[irq_sum_pkg::MS_HOLD] = hold_r;
      end
      // clear register and unmapped space read as zero
      default: rdata_nxt = irq_sum_pkg::RST_WORD;
    endcase
    // a new request racing the read zeroes it
    if (sum_rd_w && arrival_w)
      rdata_nxt = irq_sum_pkg::RST_WORD;
  end

  // data holds through the data phase and beyond
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_hrdata <= irq_sum_pkg::RST_WORD;
    else if (addr_ok_w && !i_hwrite)
      o_hrdata <= rdata_nxt;
  end
  ////////////////////////////////////////////////////////////////
  // hold after a lost read; released back in native mode
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      hold_r <= 1'b0;
    else if (sum_rd_w && arrival_w)
      hold_r <= 1'b1;
    else if (!i_privileged_code)
      hold_r <= 1'b0;
  end
  // core request: any summary bit, re-raised after the hold ends
  always_ff @(posedge i_clk)
    o_cpu_irq <= !i_rst && (|sum_w) && !hold_r;
  // bus interrupt from unmasked sticky events; reset forces low
  always_ff @(posedge i_clk)
    o_irq <= !i_rst && (|(ev_stat_q & ev_mask_r));
  ////////////////////////////////////////////////////////////////
  // one-shot bad fill parity; arming beats a same-cycle hit
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      armed_r <= 1'b0;
    else
      armed_r <= (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_CLR_LO)
        && wdata_w[irq_sum_pkg::FORCE_BAD_FILL_PARITY_BIT])
        || (armed_r && !i_bc_fill_hit);
  end
  // pulse lasts the one cycle after the armed hit
  always_ff @(posedge i_clk)
    o_bad_fill_parity <= !i_rst && armed_r && i_bc_fill_hit;
  ////////////////////////////////////////////////////////////////
  // checks
  AST_SW_GATE: assert property (@(posedge i_clk) disable iff (i_rst)
    sum_w[28:14] == (swreq_r & en_lo_r[28:14]))
    else $error("software summary not gated by enable");
  AST_SW_RSVD: assert property (@(posedge i_clk) disable iff (i_rst)
    (addr_ok_w && !i_hwrite && i_haddr == irq_sum_pkg::A_SWREQ_LO)
    |=> (o_hrdata[31:29] == 3'h0) && (o_hrdata[13:0] == 14'h0))
    else $error("software request reserved bits not zero");
  AST_SUM_EN: assert property (@(posedge i_clk) disable iff (i_rst)
    (sum_w & ~en_mask_w) == 64'h0)
    else $error("summary shows a disabled request");
  AST_ZERO_READ: assert property (@(posedge i_clk) disable iff (i_rst)
    (sum_rd_w && arrival_w) |=> (o_hrdata == 32'h0) && hold_r)
    else $error("racing summary read not zero");
  AST_PC_MAP: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(edge_req_q[1]) && en_lo_r[29] |-> sum_w[29])
    else $error("counter 0 not in lower bit");
  AST_TRAP_K: assert property (@(posedge i_clk) disable iff (i_rst)
    sum_w[3] == (en_lo_r[13] && trap_r[0] && trap_r[4]))
    else $error("kernel trap bit wrong");
  AST_TRAP_U: assert property (@(posedge i_clk) disable iff (i_rst)
    sum_w[10] |-> en_lo_r[13] && trap_r[3] && trap_r[7] && cm_w == 2'h3)
    else $error("user trap bit without its causes");
  AST_CLR_SL: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_CLR_HI) && wdata_w[0]
    && !rise_w.sl) |=> !edge_req_q[4])
    else $error("serial line request not cleared");
  AST_CLR_MCHK: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_CLR_LO) && wdata_w[28]
    && !rise_w.mchk) |=> !edge_req_q[0])
    else $error("machine check request not cleared");
  AST_FORCE_BAD_FILL_PARITY: assert property (@(posedge i_clk) disable iff (i_rst)
    (armed_r && i_bc_fill_hit && !wr_pend_r) |=> o_bad_fill_parity
    && !armed_r ##1 !o_bad_fill_parity)
    else $error("bad fill parity not one-shot");
  AST_CLR_ZERO: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_at(wr_pend_r, waddr_r, irq_sum_pkg::A_CLR_LO) && wdata_w == 32'h0
    && !i_bc_fill_hit && rise_w == '0) |=> $stable(armed_r)
    && $stable(edge_req_q))
    else $error("zero clear write changed state");
endmodule
`default_nettype wire

// [verilog/irq_sync_edge.sv]
// two-flop synchroniser with a rising-edge detector behind it
// assumes inputs are asynchronous levels or pulses of >= 2 clocks
`timescale 1ns/100ps
`default_nettype none
module irq_sync_edge #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level,
  output logic [W-1:0] o_rise
);
  logic [W-1:0] meta_r; // first stage, read only by o_level
  logic [W-1:0] prev_r; // delayed copy for edge detection

  ////////////////////////////////////////////////////////////////
  // synchroniser chain
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_r <= '0;
      o_level <= '0;
      prev_r <= '0;
    end
    else
    begin
      meta_r <= i_async;
      o_level <= meta_r;
      prev_r <= o_level;
    end
  end

  // edge looks only at synchronised stages
  assign o_rise = o_level & ~prev_r;
endmodule
`default_nettype wire
